/* File: hdl/dram_ctl_defs.vh */
// constants for the 4k x 1 dynamic ram controller
// assumes mclk at 100 MHz and a ram with an active-low strobe and open-drain data
`ifndef DRAM_CTL_DEFS_VH
`define DRAM_CTL_DEFS_VH
`define DRC_CLK_MHZ        100
`define DRC_ADDR_W         12
`define DRC_ROW_W          6
`define DRC_ROWS           64
`define DRC_REFRESH_NS     2000000
// cycle phases in ns
`define DRC_SETUP_NS       250
`define DRC_LOW_NS         300
`define DRC_PRECHG_NS      300
`define DRC_SETUP_CYC      ((`DRC_SETUP_NS * `DRC_CLK_MHZ + 999) / 1000)
`define DRC_LOW_CYC        ((`DRC_LOW_NS * `DRC_CLK_MHZ + 999) / 1000)
`define DRC_PRECHG_CYC     ((`DRC_PRECHG_NS * `DRC_CLK_MHZ + 999) / 1000)
// refresh spacing: whole period spread over all rows, rounded down, then halved for margin
`define DRC_REF_INTERVAL   ((`DRC_REFRESH_NS / 10 * `DRC_CLK_MHZ / 100) / `DRC_ROWS / 2)
`endif

/* File: hdl/dram_ctl_timer.v */
// down-counter that pulses done when a loaded count has elapsed
// assumes load and count come from logic on mclk
`timescale 1ns/1ps
`default_nettype none
module dram_ctl_timer (
    input  wire        mclk,
    input  wire        srst,
    input  wire        load,
    input  wire [15:0] count,
    output reg         done
);
    reg [15:0] cnt_q;

    // done is one pulse as the counter steps from one to zero
    always @(posedge mclk) begin
        if (srst) begin
            cnt_q <= 16'h0000;
            done  <= 1'b0;
        end else if (load) begin
            cnt_q <= count;
            done  <= 1'b0;
        end else begin
            done <= (cnt_q == 16'h0001);
            if (cnt_q != 16'h0000)
                cnt_q <= cnt_q - 16'h0001;
        end
    end
endmodule // dram_ctl_timer
`default_nettype wire

/* File: hdl/dram_ctl.v */
// controller for a 4k x 1 dynamic ram: access cycles plus interleaved row refresh
// assumes the data pin has an external pull-up; the wire level is resolved outside
// a refresh may be taken ahead of the first request after reset
`timescale 1ns/1ps
`default_nettype none
`include "dram_ctl_defs.vh"
module dram_ctl #(
    parameter REF_INTERVAL = `DRC_REF_INTERVAL
) (
    input  wire        mclk,
    input  wire        srst,
    input  wire        reqValid,
    input  wire        reqWrite,
    input  wire [11:0] reqAddr,
    input  wire        reqData,
    output reg         reqReady,
    output reg         rspValid,
    output reg         rspData,
    output reg         ramStrobeN,
    output reg         ramReadSel,
    output reg  [11:0] wordAddress,
    input  wire        ramDataIn,
    output reg         ramDataOut,
    output reg         ramDataOe
);
    // one memory cycle runs through five states:
    //   idle   strobe high, ram in standby; pick a refresh or a user request
    //   setup  address and mode settle on the pins before the strobe falls
    //   low    strobe low; the ram reads or writes the latched address
    //   pre    strobe high again; the ram precharges, write data released after its first cycle
    //   done   bump the refresh row after a refresh, back to idle
    // phase lengths come from the shared timer, loaded on entry to setup, low and pre
    // refresh beats user requests in idle, so a busy user cannot starve a row
    // limitation: one cycle in flight at a time, no read-modify-write cycle
    // trade-off: long fixed phases instead of per-grade timing, for margin
    localparam [4:0] ST_IDLE  = 5'h01;
    localparam [4:0] ST_SETUP = 5'h02;
    localparam [4:0] ST_LOW   = 5'h04;
    localparam [4:0] ST_PRE   = 5'h08;
    localparam [4:0] ST_DONE  = 5'h10;
    localparam [15:0] SETUP_CYC  = `DRC_SETUP_CYC;
    localparam [15:0] LOW_CYC    = `DRC_LOW_CYC;
    localparam [15:0] PRECHG_CYC = `DRC_PRECHG_CYC;
    localparam [31:0] REF_LIM    = REF_INTERVAL;

    // sequencer state and refresh bookkeeping
    reg  [4:0]  state_q;
    reg  [5:0]  refRow_q;
    reg  [31:0] refCnt_q;
    reg         refPend_q;

    // kind of the cycle in flight, latched when idle takes it
    reg         isRef_q;
    reg         isWrite_q;

    // data pin synchroniser
    reg         dSync1_q;
    reg         dSync2_q;

    // phase timer handshake
    reg         tLoad;
    reg  [15:0] tCount;
    wire        tDone;

    // one timer shared by all phases; only one phase runs at a time
    dram_ctl_timer uTimer (
        .mclk  (mclk),
        .srst  (srst),
        .load  (tLoad),
        .count (tCount),
        .done  (tDone)
    );

    // data pin comes from outside: two flops before use
    // both flops reset to the pulled-up idle level of the pin
    always @(posedge mclk) begin
        if (srst) begin
            dSync1_q <= 1'b1;
            dSync2_q <= 1'b1;
        end else begin
            dSync1_q <= ramDataIn;
            dSync2_q <= dSync1_q;
        end
    end

    // refresh interval counter; pending refresh set wins over its clear
    // the counter wraps every REF_LIM cycles; idle is the only taker of the flag
    always @(posedge mclk) begin
        if (srst) begin
            refCnt_q  <= 32'h00000000;
            refPend_q <= 1'b0;
        end else begin
            if (refCnt_q >= REF_LIM - 32'h00000001) begin
                refCnt_q  <= 32'h00000000;
                refPend_q <= 1'b1;
            end else begin
                refCnt_q <= refCnt_q + 32'h00000001;
                if (state_q == ST_IDLE && refPend_q)
                    refPend_q <= 1'b0;
            end
        end
    end

    // timer load requests per phase
    // precharge ends in pre with no reload; done falls straight back to idle
    always @* begin
        tLoad  = 1'b0;
        tCount = SETUP_CYC;
        case (state_q)
            ST_IDLE: begin
                if (refPend_q || reqValid) begin
                    tLoad  = 1'b1;
                    tCount = SETUP_CYC;
                end
            end
            ST_SETUP: begin
                if (tDone) begin
                    tLoad  = 1'b1;
                    tCount = LOW_CYC;
                end
            end
            ST_LOW: begin
                if (tDone) begin
                    tLoad  = 1'b1;
                    tCount = PRECHG_CYC;
                end
            end
            default: begin
                tLoad  = 1'b0;
                tCount = SETUP_CYC;
            end
        endcase
    end

    // cycle sequencer: refresh takes priority so no row starves
    always @(posedge mclk) begin
        if (srst) begin
            state_q     <= ST_IDLE;
            refRow_q    <= 6'h00;
            isRef_q     <= 1'b0;
            isWrite_q   <= 1'b0;
            reqReady    <= 1'b0;
            rspValid    <= 1'b0;
            rspData     <= 1'b0;
            ramStrobeN  <= 1'b1;
            ramReadSel  <= 1'b1;
            wordAddress <= 12'h000;
            ramDataOut  <= 1'b0;
            ramDataOe   <= 1'b0;
        end else begin
            reqReady <= 1'b0;
            rspValid <= 1'b0;
            case (state_q)
                // pins return to the standby levels while waiting
                ST_IDLE: begin
                    ramStrobeN <= 1'b1;
                    ramDataOe  <= 1'b0;
                    ramReadSel <= 1'b1;
                    if (refPend_q) begin
                        // refresh is a read whose result is thrown away
                        isRef_q     <= 1'b1;
                        isWrite_q   <= 1'b0;
                        // column lines left at zero; they do not matter here
                        wordAddress <= {6'h00, refRow_q};
                        state_q     <= ST_SETUP;
                    end else if (reqValid) begin
                        isRef_q     <= 1'b0;
                        isWrite_q   <= reqWrite;
                        wordAddress <= reqAddr;
                        ramReadSel  <= ~reqWrite;
                        ramDataOut  <= reqData;
                        // writes sink the pin only for a zero, the pull-up gives a one; reads leave the pin to the ram and its pull-up
                        ramDataOe   <= reqWrite;
                        reqReady    <= 1'b1;
                        state_q     <= ST_SETUP;
                    end
                end

                ST_SETUP: begin
                    // timer was loaded on the way in from idle
                    // address settled a full setup before the strobe falls
                    if (tDone) begin
                        ramStrobeN <= 1'b0;
                        state_q    <= ST_LOW;
                    end
                end

                ST_LOW: begin
                    if (tDone) begin
                        // two sync flops plus the ram access time fit well inside the low phase
                        // sample read data before strobe rises; pin held low only by ram
                        if (!isRef_q && !isWrite_q) begin
                            rspData  <= dSync2_q;
                            rspValid <= 1'b1;
                        end
                        ramStrobeN <= 1'b1;
                        state_q    <= ST_PRE;
                    end
                end

                ST_PRE: begin
                    // hold write data through the rising strobe, then release
                    // strobe is already high here, so the ram has taken the write bit
                    ramDataOe  <= 1'b0;
                    ramReadSel <= 1'b1;
                    if (tDone)
                        state_q <= ST_DONE;
                end

                ST_DONE: begin
                    // six-bit row counter wraps after the last row, visiting rows in order
                    if (isRef_q)
                        refRow_q <= refRow_q + 6'h01;
                    state_q <= ST_IDLE;
                end

                // unreachable codes fall back to idle
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // dram_ctl
`default_nettype wire

/* File: verif/dra_ctl_asserts.sv */
// port-level checks on the dram controller strobe, address and data pin
// assumes one clock domain, mclk, with srst as its reset
`timescale 1ns/1ps
`default_nettype none
module dra_ctl_asserts #(
    parameter int REF_INTERVAL = 1562
) (
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic        reqValid,
    input wire logic        reqReady,
    input wire logic        rspValid,
    input wire logic        ramStrobeN,
    input wire logic        ramReadSel,
    input wire logic [11:0] wordAddress,
    input wire logic        ramDataOe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    logic [15:0] gapCnt_q;
    // cycles since strobe was last low; a stalled refresh shows as a long gap
    always @(posedge mclk) gapCnt_q <= (srst || !ramStrobeN) ? 16'h0000 : gapCnt_q + 16'h0001;
    sequence sLowRun;
        !ramStrobeN [*8];
    endsequence
    sequence sOnePulse;
        ramStrobeN ##1 !reqReady;
    endsequence
    a_addr_held: assert property (!ramStrobeN |-> $stable(wordAddress) && $stable(ramReadSel))
        else $error("address or mode moved under strobe");
    a_oe_write: assert property (ramDataOe |-> !ramReadSel)
        else $error("data pin driven in a read");
    a_low_run: assert property ($fell(ramStrobeN) |-> sLowRun)
        else $error("strobe low too short");
    a_ready_idle: assert property (reqReady |-> sOnePulse)
        else $error("request taken under strobe");
    a_ready_cause: assert property (reqReady |-> $past(reqValid))
        else $error("ready without request");
    a_rsp_read: assert property (rspValid |-> ramReadSel && ramStrobeN ##1 !rspValid)
        else $error("response outside a read");
    a_wr_data: assert property ($fell(ramStrobeN) && !ramReadSel |-> ramDataOe)
        else $error("write cycle without data");
    a_ref_gap: assert property (gapCnt_q <= 2 * REF_INTERVAL + 200)
        else $error("refresh gap too long");
endmodule // dra_ctl_asserts
bind dram_ctl dra_ctl_asserts #(.REF_INTERVAL(REF_INTERVAL)) u_chk (.mclk, .srst, .reqValid, .reqReady,
    .rspValid, .ramStrobeN, .ramReadSel, .wordAddress, .ramDataOe);
`default_nettype wire

/* File: verif/dra_ram_model.sv */
// behavioural 4k x 1 dynamic ram, strobe is its only cycle clock
// assumes the bench resolves the shared data wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module dra_ram_model (
    input  wire logic        ramStrobeN,
    input  wire logic        ramReadSel,
    input  wire logic [11:0] wordAddress,
    input  wire logic        dataWire,
    output var  logic        ramPullDown,
    output var  logic [63:0] rowSeen
);
    logic [4095:0] mem = '0;
    logic [11:0]   addrLat = 12'h000;
    logic          rdLat = 1'b1;
    initial rowSeen = '0;
    // address and mode latched at strobe fall, so later changes are ignored
    always @(negedge ramStrobeN) begin
        addrLat = wordAddress;
        rdLat = ramReadSel;
        rowSeen[wordAddress[5:0]] = 1'b1;
    end
    // wire taken as input only in writes, at the end of the low phase
    always @(posedge ramStrobeN) if (!rdLat) mem[addrLat] = dataWire;
    // sinks only for a stored zero; standby releases the pin
    assign ramPullDown = !ramStrobeN && rdLat && !mem[addrLat];
endmodule // dra_ram_model
`default_nettype wire

/* File: verif/dynamic_ram_4kx1_access_test.sv */
// self-checking bench: controller against the ram model
// assumes REF_INTERVAL of 200 to keep refresh sweeps short
`timescale 1ns/1ps
`default_nettype none
module dynamic_ram_4kx1_access_test;
    logic        mclk, srst, reqValid, reqWrite, reqData, reqReady, rspValid, rspData;
    logic        ramStrobeN, ramReadSel, ramDataOut, ramDataOe, ramPullDown, dataWire;
    logic [11:0] reqAddr, wordAddress;
    logic [63:0] rowSeen;
    int          err_total, n_checks;
    // pull-up wins unless someone sinks the wire
    assign dataWire = !(ramPullDown || (ramDataOe && !ramDataOut));
    dram_ctl #(.REF_INTERVAL(200)) u_dut (.mclk, .srst, .reqValid, .reqWrite, .reqAddr, .reqData,
        .reqReady, .rspValid, .rspData, .ramStrobeN, .ramReadSel, .wordAddress,
        .ramDataIn(dataWire), .ramDataOut, .ramDataOe);
    dra_ram_model u_ram (.ramStrobeN, .ramReadSel, .wordAddress, .dataWire, .ramPullDown, .rowSeen);
    task automatic close_out(input int bad);
        err_total += bad;
        if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask
    // request held until ready is seen at an edge
    task automatic access(input logic wr, input logic [11:0] a, input logic d);
        int i;
        i = 0;
        reqValid <= 1'b1; reqWrite <= wr; reqAddr <= a; reqData <= d;
        do begin @(posedge mclk); i++; end while (reqReady !== 1'b1 && i < 400);
        reqValid <= 1'b0;
        if (i >= 400) close_out(1);
        // one edge with valid low before the next request may raise it again
        @(posedge mclk);
    endtask
    task automatic read_check(input logic [11:0] a, input logic exp);
        int i;
        i = 0;
        access(1'b0, a, 1'b0);
        do begin @(posedge mclk); i++; end while (rspValid !== 1'b1 && i < 120);
        if (i >= 120) close_out(1);
        check({63'h0, rspData}, {63'h0, exp});
    endtask
    // mid-run reset: pins go back to standby levels, then traffic resumes
    task automatic t_reset();
        logic [16:0] pins;
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        pins = {ramStrobeN, ramReadSel, ramDataOe, reqReady, rspValid, wordAddress};
        check({47'h0, pins}, {47'h0, 17'h18000});
        srst <= 1'b0;
    endtask
    // idle controller must sweep every row on its own
    task automatic t_refresh();
        int i;
        for (i = 0; i < 20000 && !(&rowSeen); i++) @(posedge mclk);
        check(rowSeen, {64{1'b1}});
    endtask
    // same row, other columns, back-to-back writes, then overwrite
    task automatic t_data();
        logic [11:0] adr [5] = '{12'h000, 12'h040, 12'hFFF, 12'hFC0, 12'hAAA};
        for (int k = 0; k < 5; k++) access(1'b1, adr[k], !k[0]);
        for (int k = 0; k < 5; k++) read_check(adr[k], !k[0]);
        access(1'b1, 12'hFFF, 1'b0);
        read_check(12'hFFF, 1'b0);
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        srst = 1'b1; reqValid = 1'b0; reqWrite = 1'b0; reqAddr = 12'h000; reqData = 1'b0;
        err_total = 0; n_checks = 0;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        t_refresh();
        t_reset();
        t_data();
        close_out(0);
    end
endmodule // dynamic_ram_4kx1_access_test
`default_nettype wire
